// >>> verilog/hpb_cfg_regs.sv
/*
 Configuration register slice of the hub-to-PCI bridge function: the
 prefetchable memory limit, upper I/O words, interrupt line and the upper
 bridge control bits, plus the address checks that use them.
 Assumes single-cycle configuration requests synchronous to sys_clk and
 PCI memory addresses presented with a one-cycle request strobe.
*/
`timescale 1ns/10ps
`include "hpb_cfg_consts.svh"
`default_nettype none

module hpb_cfg_regs
   import hpb_cfg_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Configuration cycle port
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rd_valid,
   // PCI memory cycle decode
   input wire logic [31:0] pci_mem_addr,
   input wire logic pci_mem_req,
   output logic vga_refuse,
   output logic pref_below_limit,
   output logic [31:0] pref_limit_top,
   // Bridge behaviour controls
   output logic bridge_irq,
   output logic fast_b2b_en,
   output logic sec_bus_reset,
   output logic master_abort_mode_eff,
   output logic vga_en
);

   // ==================================================================
   // Storage
   hpb_mb_t pref_limit_reg;
   logic mam_reg;
   logic vga_reg;
   logic [31:0] rdata_reg;
   logic rd_valid_reg;
   logic vga_refuse_reg;
   logic below_reg;
   hpb_dwidx_t cfg_idx;

   assign cfg_idx = cfg_addr[7:2];

   // Read mux, one function used only by the read path; the write path decodes the same indices itself
   function automatic hpb_dword_t read_dword(input hpb_dwidx_t idx, input hpb_mb_t lim,
                                             input logic mam, input logic vga);
      hpb_dword_t d;
      d = 32'h0000_0000;
      unique case (idx)
         `HPB_DW_PREF:
         begin
            d[31:20] = lim;
         end
         `HPB_DW_IO_UPPER:
         begin
            d = 32'h0000_0000;
         end
         `HPB_DW_IRQ_BCTL:
         begin
            // line byte stays zero; bits 7,6 zero
            d[16 + `HPB_BCTL_MAM_BIT] = mam;
            d[16 + `HPB_BCTL_VGA_BIT] = vga;
         end
         default:
         begin
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction : read_dword

   // ==================================================================
   // Prefetchable limit, bytes 26h and 27h of the dword
   // writable limit field
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         pref_limit_reg <= `HPB_PREF_LIMIT_RST;
      else if (cfg_wr && cfg_idx == `HPB_DW_PREF)
      begin
         if (cfg_be[2])
            pref_limit_reg[3:0] <= cfg_wdata[23:20];
         if (cfg_be[3])
            pref_limit_reg[11:4] <= cfg_wdata[31:24];
      end
   end

   // Bridge control low byte; only bits 5 and 3 hold state here
   // master abort mode stored for software
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mam_reg <= `HPB_MAM_RST;
         vga_reg <= `HPB_VGA_RST;
      end
      else if (cfg_wr && cfg_idx == `HPB_DW_IRQ_BCTL && cfg_be[2])
      begin
         mam_reg <= cfg_wdata[16 + `HPB_BCTL_MAM_BIT];
         vga_reg <= cfg_wdata[16 + `HPB_BCTL_VGA_BIT];
      end
   end

   // Registered read answer, valid one cycle after the request
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_reg <= 32'h0000_0000;
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= cfg_rd;
         if (cfg_rd)
            rdata_reg <= read_dword(cfg_idx, pref_limit_reg, mam_reg, vga_reg);
      end
   end

   // ==================================================================
   // Memory cycle decode, registered so the answers are glitch free
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vga_refuse_reg <= 1'b0;
         below_reg <= 1'b0;
      end
      else
      begin
         vga_refuse_reg <= pci_mem_req && vga_reg && pci_mem_addr >= `HPB_VGA_LO
                           && pci_mem_addr <= `HPB_VGA_HI;
         below_reg <= pci_mem_req && pci_mem_addr <= {pref_limit_reg, `HPB_LOW_MB_ONES};
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_rd_valid = rd_valid_reg;
   assign vga_refuse = vga_refuse_reg;
   assign pref_below_limit = below_reg;
   assign pref_limit_top = {pref_limit_reg, `HPB_LOW_MB_ONES};
   assign vga_en = vga_reg;

   // Fixed behaviour: the bridge has no interrupt source, no fast
   // back-to-back, no secondary reset, and aborts as if mode were 0.
   // Tying these keeps downstream logic from ever seeing mam_reg.
   // no interrupt from the bridge
   assign bridge_irq = 1'b0;
   assign fast_b2b_en = 1'b0;
   assign sec_bus_reset = 1'b0;
   // abort handling as if bit clear
   assign master_abort_mode_eff = 1'b0;

   // ==================================================================
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   limit_write_read_a: assert property (
      cfg_wr && cfg_idx == `HPB_DW_PREF && cfg_be[3:2] == 2'b11 ##1 cfg_rd && cfg_idx == `HPB_DW_PREF
      |=> cfg_rdata[31:20] == $past(cfg_wdata[31:20], 2) && cfg_rdata[19:0] == 20'h00000)
      else $error("prefetch limit readback wrong");

   io_base_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IO_UPPER |=> cfg_rd_valid && cfg_rdata[15:0] == 16'h0000)
      else $error("io base upper not zero");

   io_limit_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IO_UPPER |=> cfg_rdata[31:16] == 16'h0000)
      else $error("io limit upper not zero");

   irq_line_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IRQ_BCTL |=> cfg_rdata[7:0] == 8'h00)
      else $error("interrupt line not zero");

   no_bridge_irq_a: assert property (
      bridge_irq == 1'b0)
      else $error("bridge raised interrupt");

   fbb_bit_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IRQ_BCTL |=> cfg_rdata[16 + `HPB_BCTL_FBB_BIT] == 1'b0
      && !fast_b2b_en)
      else $error("fast back-to-back visible");

   sbr_bit_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IRQ_BCTL |=> cfg_rdata[16 + `HPB_BCTL_SBR_BIT] == 1'b0
      && !sec_bus_reset)
      else $error("secondary reset visible");

   mam_stored_a: assert property (
      cfg_wr && cfg_idx == `HPB_DW_IRQ_BCTL && cfg_be[2] ##1 cfg_rd && cfg_idx == `HPB_DW_IRQ_BCTL
      |=> cfg_rdata[16 + `HPB_BCTL_MAM_BIT] == $past(cfg_wdata[16 + `HPB_BCTL_MAM_BIT], 2))
      else $error("master abort mode not stored");

   mam_ignored_a: assert property (
      $rose(mam_reg) |-> !master_abort_mode_eff [*3])
      else $error("master abort mode took effect");

   vga_window_a: assert property (
      pci_mem_req && vga_en && pci_mem_addr[31:17] == 15'h0005 |=> vga_refuse)
      else $error("vga cycle not refused");

   vga_off_a: assert property (
      !vga_en || !pci_mem_req |=> !vga_refuse)
      else $error("vga refuse without cause");

   limit_cover_a: assert property (
      pci_mem_req && pci_mem_addr[31:20] == pref_limit_reg |=> pref_below_limit)
      else $error("limit megabyte not covered");

   rd_valid_follow_a: assert property (
      cfg_rd |=> cfg_rd_valid)
      else $error("read answer missing");

   rd_valid_pulse_a: assert property (
      !cfg_rd |=> !cfg_rd_valid)
      else $error("read valid without request");

   rdata_hold_a: assert property (
      !cfg_rd |=> $stable(cfg_rdata))
      else $error("read data moved without read");

   limit_keep_a: assert property (
      !(cfg_wr && cfg_idx == `HPB_DW_PREF) |=> $stable(pref_limit_top))
      else $error("limit changed without write");

   limit_nibble_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_PREF |=> cfg_rdata[19:0] == 20'h00000)
      else $error("limit low bits not zero");

   limit_top_ones_a: assert property (
      pref_limit_top[19:0] == `HPB_LOW_MB_ONES)
      else $error("limit top not megabyte aligned");

   limit_above_a: assert property (
      pci_mem_req && pci_mem_addr > pref_limit_top |=> !pref_below_limit)
      else $error("address above limit accepted");

   below_idle_a: assert property (
      !pci_mem_req |=> !pref_below_limit)
      else $error("limit answer without request");

   io_word_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IO_UPPER |=> cfg_rdata == 32'h0000_0000)
      else $error("upper io dword not zero");

   ctrl_high_zero_a: assert property (
      cfg_rd && cfg_idx == `HPB_DW_IRQ_BCTL |=> cfg_rdata[31:24] == 8'h00
      && cfg_rdata[15:8] == 8'h00)
      else $error("reserved control bits not zero");

   fbb_tied_a: assert property (
      !fast_b2b_en)
      else $error("fast back-to-back enabled");

   sbr_tied_a: assert property (
      !sec_bus_reset)
      else $error("secondary reset driven");

   mam_eff_tied_a: assert property (
      !master_abort_mode_eff)
      else $error("abort mode effective");

   mam_write_a: assert property (
      cfg_wr && cfg_idx == `HPB_DW_IRQ_BCTL && cfg_be[2]
      |=> mam_reg == $past(cfg_wdata[16 + `HPB_BCTL_MAM_BIT]))
      else $error("abort mode write lost");

   vga_write_a: assert property (
      cfg_wr && cfg_idx == `HPB_DW_IRQ_BCTL && cfg_be[2]
      |=> vga_en == $past(cfg_wdata[16 + `HPB_BCTL_VGA_BIT]))
      else $error("vga enable write lost");

   vga_outside_a: assert property (
      pci_mem_req && (pci_mem_addr < `HPB_VGA_LO || pci_mem_addr > `HPB_VGA_HI) |=> !vga_refuse)
      else $error("cycle outside vga window refused");

endmodule : hpb_cfg_regs
`default_nettype wire

// >>> verilog/hpb_cfg_consts.svh
/*
 Constants for the bridge configuration register slice: dword offsets,
 field positions, reset values and the legacy VGA memory window.
 Assumes byte-addressed configuration cycles carried as aligned dwords.
*/
`ifndef HPB_CFG_CONSTS_SVH
`define HPB_CFG_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define HPB_OFS_PREF_MEM_LIMIT 8'h26
`define HPB_OFS_IO_BASE_UPPER 8'h30
`define HPB_OFS_IO_LIMIT_UPPER 8'h32
`define HPB_OFS_IRQ_ROUTE_LINE 8'h3c
`define HPB_OFS_BRIDGE_CONTROL 8'h3e

// Dword indices (byte offset bits 7:2) holding those registers
`define HPB_DW_PREF 6'h09
`define HPB_DW_IO_UPPER 6'h0c
`define HPB_DW_IRQ_BCTL 6'h0f

// =====================================================================
// Field positions and reset values
`define HPB_PREF_LIMIT_RST 12'h000
`define HPB_BCTL_MAM_BIT 5
`define HPB_BCTL_VGA_BIT 3
`define HPB_BCTL_FBB_BIT 7
`define HPB_BCTL_SBR_BIT 6
`define HPB_MAM_RST 1'b0
`define HPB_VGA_RST 1'b0
`define HPB_LOW_MB_ONES 20'hfffff

// =====================================================================
// Legacy VGA memory window
`define HPB_VGA_LO 32'h000a0000
`define HPB_VGA_HI 32'h000bffff

`endif

// >>> verilog/hpb_cfg_pkg.sv
/*
 Types shared by the bridge configuration register slice.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package hpb_cfg_pkg;
   // One configuration dword
   typedef logic [31:0] hpb_dword_t;
   // Dword index within configuration space
   typedef logic [5:0] hpb_dwidx_t;
   // Upper twelve address bits of a 1 MB block
   typedef logic [11:0] hpb_mb_t;
endpackage : hpb_cfg_pkg
`default_nettype wire

// >>> tb/hpb_pci_agent.sv
/*
 PCI agent model presenting memory addresses to the bridge decode.
 Assumes the bench launches each request one cycle ahead.
*/
`timescale 1ns/10ps
`default_nettype none
module hpb_pci_agent
(
   // Clock
   input wire logic sys_clk,
   // Bench command
   input wire logic go,
   input wire logic [31:0] addr,
   // Address phase towards the bridge
   output logic pci_mem_req,
   output logic [31:0] pci_mem_addr
);
   // Idle bus inverts its address every cycle, so a stale value never holds for two cycles
   always_ff @(posedge sys_clk)
   begin
      pci_mem_req <= go;
      pci_mem_addr <= go ? addr : ~pci_mem_addr;
   end
endmodule : hpb_pci_agent
`default_nettype wire

// >>> tb/hpb_cfg_regs_tb.sv
/*
 Self-checking bench for the bridge configuration register slice.
 Assumes the PCI agent model drives the decode port.
*/
`timescale 1ns/10ps
`default_nettype none
module hpb_cfg_regs_tb
   import hpb_cfg_pkg::*;
;
   logic sys_clk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, go = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0;
   hpb_dword_t cfg_wdata = '0, addr = '0, cfg_rdata, pref_limit_top, pci_mem_addr;
   logic cfg_rd_valid, pci_mem_req, vga_refuse, pref_below_limit, bridge_irq;
   logic fast_b2b_en, sec_bus_reset, master_abort_mode_eff, vga_en;
   int n_mismatch = 0, num_checks = 0;
   hpb_mb_t lim = '0;
   hpb_dword_t tbl [5];
   // =====================================================================
   // Clock, design and far side
   always #5 sys_clk = ~sys_clk;
   hpb_cfg_regs hpb_cfg_regs_i (.sys_clk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
      .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .pci_mem_addr, .pci_mem_req, .vga_refuse,
      .pref_below_limit, .pref_limit_top, .bridge_irq, .fast_b2b_en, .sec_bus_reset,
      .master_abort_mode_eff, .vga_en);
   hpb_pci_agent hpb_pci_agent_i (.sys_clk, .go, .addr, .pci_mem_req, .pci_mem_addr);
   // =====================================================================
   // Tasks
   task automatic chk(input hpb_dword_t got, input hpb_dword_t exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cwr(input logic [7:0] a, input logic [3:0] be, input hpb_dword_t d);
      @(posedge sys_clk);
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
   endtask : cwr
   // Read answer comes exactly one cycle after the request
   task automatic crd(input logic [7:0] a, input hpb_dword_t exp);
      @(posedge sys_clk);
      cfg_addr <= a;
      cfg_rd <= 1'b1;
      @(posedge sys_clk);
      cfg_rd <= 1'b0;
      #1;
      chk({31'h0, cfg_rd_valid}, 32'h1);
      chk(cfg_rdata, exp);
   endtask : crd
   // Limit covers its whole megabyte
   function automatic logic [1:0] exp_dec(input hpb_dword_t a, input logic vga);
      return {vga && a >= 32'h000a0000 && a <= 32'h000bffff, a <= {lim, 20'hfffff}};
   endfunction : exp_dec
   task automatic dec(input hpb_dword_t a, input logic vga);
      @(posedge sys_clk);
      go <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({vga_refuse, pref_below_limit}, exp_dec(a, vga));
   endtask : dec
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   // =====================================================================
   // Hang guard, far beyond the expected run
   initial
   begin
      #500000;
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      void'($urandom(37));
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      #1;
      chk(pref_limit_top, 32'h000fffff);
      crd(8'h24, 32'h0);
      crd(8'h3c, 32'h0);
      $display("test reset values done");
      // Limit field, corner values first
      for (int i = 0; i < 6; i++)
      begin
         lim = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
         cwr(8'h26, 4'hc, {lim, 20'hfffff});
         crd(8'h24, {lim, 20'h0});
         chk(pref_limit_top, {lim, 20'hfffff});
         dec({lim, 20'hfffff}, 1'b0);
         dec({lim, 20'hfffff} + 32'h1, 1'b0);
         dec($urandom, 1'b0);
      end
      cwr(8'h24, 4'h3, 32'hffffffff);
      crd(8'h24, {lim, 20'h0});
      cwr(8'h10, 4'hf, 32'hffffffff);
      crd(8'h10, 32'h0);
      $display("test limit done");
      cwr(8'h30, 4'hf, 32'hffffffff);
      crd(8'h30, 32'h0);
      cwr(8'h3c, 4'hf, 32'hffffffff);
      crd(8'h3c, 32'h00280000);
      chk({28'h0, bridge_irq, fast_b2b_en, sec_bus_reset, master_abort_mode_eff}, 32'h0);
      tbl = '{32'h000a0000, 32'h000bffff, 32'h0009ffff, 32'h000c0000, $urandom};
      foreach (tbl[i])
      begin
         dec(tbl[i], 1'b1);
      end
      cwr(8'h3c, 4'h4, 32'h00200000);
      crd(8'h3c, 32'h00200000);
      chk({31'h0, vga_en}, 32'h0);
      chk({31'h0, master_abort_mode_eff}, 32'h0);
      dec(32'h000a0000, 1'b0);
      $display("test control bits done");
      complete_run();
   end
endmodule : hpb_cfg_regs_tb
`default_nettype wire
